// File: srtc_map.svh
// Register map, field positions, reset values and timing counts of the serial clock calendar
`ifndef SRTC_MAP_SVH
`define SRTC_MAP_SVH

// ****************************************
// Command byte fields
// ****************************************
`define SRTC_CMD_EN_BIT     7
`define SRTC_CMD_RAM_BIT    6
`define SRTC_CMD_ADDR_HI    5
`define SRTC_CMD_ADDR_LO    1
`define SRTC_CMD_RD_BIT     0
`define SRTC_BURST_ADDR     5'h1F

// ****************************************
// Address space
// ****************************************
`define SRTC_SEC_IDX        3'h0
`define SRTC_MIN_IDX        3'h1
`define SRTC_HOUR_IDX       3'h2
`define SRTC_DATE_IDX       3'h3
`define SRTC_MONTH_IDX      3'h4
`define SRTC_DAY_IDX        3'h5
`define SRTC_YEAR_IDX       3'h6
`define SRTC_CAL_REGS       5'h07
`define SRTC_CTRL_ADDR      5'h07
`define SRTC_TRICKLE_ADDR   5'h08
`define SRTC_CLK_BURST_LAST 5'h07
`define SRTC_RAM_DEPTH      5'h1F
`define SRTC_RAM_LAST       5'h1E

// ****************************************
// Field positions
// ****************************************
`define SRTC_HALT_BIT       7
`define SRTC_H12_BIT        7
`define SRTC_PM_BIT         5
`define SRTC_WP_BIT         7

// ****************************************
// Reset values
// ****************************************
`define SRTC_RST_SEC        8'h80
`define SRTC_RST_MIN        8'h00
`define SRTC_RST_HOUR       8'h00
`define SRTC_RST_DATE       8'h01
`define SRTC_RST_MONTH      8'h01
`define SRTC_RST_DAY        8'h01
`define SRTC_RST_YEAR       8'h00
`define SRTC_RST_WP         1'b0
`define SRTC_RST_TRICKLE    8'h00

// ****************************************
// Timing
// ****************************************
`define SRTC_OSC_PER_SEC    32768

`endif

// File: srtc_pkg.sv
// Types shared by the serial clock calendar modules
package srtc_pkg;

  typedef logic [7:0] srtc_byte_t;
  typedef srtc_byte_t srtc_regs_t [7];

  typedef enum logic [4:0] {
    SRTC_IDLE = 5'h01,
    SRTC_CMD  = 5'h02,
    SRTC_WR   = 5'h04,
    SRTC_RD   = 5'h08,
    SRTC_DONE = 5'h10
  } srtc_state_t;

endpackage

// File: srtc_cal_if.sv
// Carrier between the serial engine, the calendar and the seconds divider
interface srtc_cal_if;
  import srtc_pkg::*;

  logic       wr_en;
  logic [2:0] wr_idx;
  srtc_byte_t wr_byte;
  logic       ld_all;
  srtc_regs_t ld_bytes;
  logic       snap;
  srtc_regs_t live;
  srtc_regs_t shadow;
  logic       halt;
  logic       sec_tick;

  modport ctl  (output wr_en, wr_idx, wr_byte, ld_all, ld_bytes, snap,
                input  live, shadow);
  modport cal  (input  wr_en, wr_idx, wr_byte, ld_all, ld_bytes, snap, sec_tick,
                output live, shadow, halt);
  modport tick (input  halt,
                output sec_tick);
endinterface

// File: srtc_tick.sv
// Oscillator sampler and seconds divider
`include "srtc_map.svh"
module srtc_tick
  import srtc_pkg::*;
#(
  parameter int OSC_PER_SEC = `SRTC_OSC_PER_SEC
) (
  // System
  input  wire logic clk,
  input  wire logic srst,
  // Oscillator
  input  wire logic crystal_in_pin,
  output logic      crystal_out_pin,
  // Calendar side
  srtc_cal_if.tick  bus
);
  localparam int CW = $clog2(OSC_PER_SEC + 1);

  // ****************************************
  // Oscillator sampling
  // ****************************************
  logic          xt_m;
  logic          xt_q;
  logic          xt_d;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;
  logic          xo_reg;
  logic          xo_next;

  always_ff @(posedge clk) begin
    xt_m <= crystal_in_pin;
    xt_q <= xt_m;
    xt_d <= xt_q;
  end

  // ****************************************
  // Divider
  // ****************************************
  always_comb begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    // Stopped oscillator drives its output low
    xo_next   = bus.halt ? 1'b0 : ~xt_q;
    if (bus.halt) begin
      cnt_next = '0;
    end else if (xt_q && !xt_d) begin
      if (cnt_reg == CW'(OSC_PER_SEC - 1)) begin
        cnt_next  = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
      xo_reg   <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
      xo_reg   <= xo_next;
    end
  end

  assign bus.sec_tick    = tick_reg;
  assign crystal_out_pin = xo_reg;
endmodule

// File: srtc_calendar.sv
// BCD clock calendar counters with burst shadow copy
`include "srtc_map.svh"
module srtc_calendar
  import srtc_pkg::*;
(
  // System
  input  wire logic clk,
  input  wire logic srst,
  // Engine side
  srtc_cal_if.cal   bus
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    logic [7:0] inc;
    inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    return (v == last) ? {1'b1, first} : {1'b0, inc};
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02:                      month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default:                    month_last = 8'h31;
    endcase
  endfunction

  // ****************************************
  // Counters
  // ****************************************
  srtc_regs_t cal_reg;
  srtc_regs_t cal_next;
  srtc_regs_t shd_reg;
  srtc_regs_t shd_next;

  always_comb begin
    logic [8:0] s;
    logic       carry;
    logic [7:0] h;
    s        = 9'h000;
    carry    = 1'b0;
    h        = cal_reg[`SRTC_HOUR_IDX];
    cal_next = cal_reg;
    shd_next = bus.snap ? cal_reg : shd_reg;
    if (bus.ld_all) begin
      cal_next = bus.ld_bytes;
    end else if (bus.wr_en) begin
      cal_next[bus.wr_idx] = bus.wr_byte;
    end else if (bus.sec_tick) begin
      s = bcd_step({1'b0, cal_reg[`SRTC_SEC_IDX][6:0]}, 8'h59, 8'h00);
      cal_next[`SRTC_SEC_IDX] = {cal_reg[`SRTC_SEC_IDX][`SRTC_HALT_BIT], s[6:0]};
      if (s[8]) begin
        s = bcd_step(cal_reg[`SRTC_MIN_IDX], 8'h59, 8'h00);
        cal_next[`SRTC_MIN_IDX] = s[7:0];
        carry = s[8];
      end
      if (carry) begin
        carry = 1'b0;
        if (h[`SRTC_H12_BIT]) begin
          if (h[4:0] == 5'h12) begin
            h[4:0] = 5'h01;
          end else if (h[4:0] == 5'h11) begin
            h[4:0] = 5'h12;
            carry  = h[`SRTC_PM_BIT];
            h[`SRTC_PM_BIT] = ~h[`SRTC_PM_BIT];
          end else begin
            s = bcd_step({3'h0, h[4:0]}, 8'h12, 8'h01);
            h[4:0] = s[4:0];
          end
        end else begin
          s     = bcd_step({2'h0, h[5:0]}, 8'h23, 8'h00);
          h     = {2'h0, s[5:0]};
          carry = s[8];
        end
        cal_next[`SRTC_HOUR_IDX] = h;
      end
      if (carry) begin
        s = bcd_step(cal_reg[`SRTC_DAY_IDX], 8'h07, 8'h01);
        cal_next[`SRTC_DAY_IDX] = s[7:0];
        s = bcd_step(cal_reg[`SRTC_DATE_IDX],
                     month_last(cal_reg[`SRTC_MONTH_IDX], cal_reg[`SRTC_YEAR_IDX]),
                     8'h01);
        cal_next[`SRTC_DATE_IDX] = s[7:0];
        carry = s[8];
      end
      if (carry) begin
        s = bcd_step(cal_reg[`SRTC_MONTH_IDX], 8'h12, 8'h01);
        cal_next[`SRTC_MONTH_IDX] = s[7:0];
        carry = s[8];
      end
      if (carry) begin
        s = bcd_step(cal_reg[`SRTC_YEAR_IDX], 8'h99, 8'h00);
        cal_next[`SRTC_YEAR_IDX] = s[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cal_reg <= '{`SRTC_RST_SEC, `SRTC_RST_MIN, `SRTC_RST_HOUR, `SRTC_RST_DATE,
                   `SRTC_RST_MONTH, `SRTC_RST_DAY, `SRTC_RST_YEAR};
      shd_reg <= '{default: 8'h00};
    end else begin
      cal_reg <= cal_next;
      shd_reg <= shd_next;
    end
  end

  assign bus.live   = cal_reg;
  assign bus.shadow = shd_reg;
  assign bus.halt   = cal_reg[`SRTC_SEC_IDX][`SRTC_HALT_BIT];
endmodule

// File: srtc_top.sv
// Serial clock calendar: three-wire port, scratchpad and control registers
//
// Functional notes
// - Command bit 7 must be one; when zero no write is performed.
// - Command bit 6 picks clock space (0) or scratchpad RAM (1).
// - Command bits 1-5 are the address; bit 0 one means read.
// - Command byte arrives least significant bit first.
// - Raising transfer-select starts the command sequence.
// - Transfer-select low aborts the transfer and releases the data line.
// - Inputs sampled on shift clock rise; outputs driven on its fall.
// - Write data byte follows command, LSB first; later cycles ignored.
// - Read byte goes out LSB first, first bit on next fall.
// - Reads continue byte after byte while transfer-select stays high.
// - Data line released at every shift clock rise during reads.
// - Address 31 means burst, starting at bit 0 of address 0.
// - No storage at clock addresses 9-31 or RAM address 31.
// - Clock burst write commits only after all eight bytes.
// - RAM burst write commits each byte as it completes.
// - Time and calendar registers hold BCD values.
// - Month lengths and leap-year February handled up to 2100.
// - Seconds bit 7 halts oscillator and timekeeping; zero restarts.
// - Hours bit 7 selects 12-hour mode; bit 5 is PM or twenty-hours.
// - Control register bits 0-6 always read zero.
// - Control bit 7 set blocks writes to every other register.
// - Clock burst read served from a copy taken at its start.
// - Write-protect at clock burst write request blocks all eight registers.
`include "srtc_map.svh"
module srtc_top
  import srtc_pkg::*;
#(
  parameter int OSC_PER_SEC = `SRTC_OSC_PER_SEC
) (
  // System
  input  wire logic clk,
  input  wire logic srst,
  // Serial port
  input  wire logic xfer_sel,
  input  wire logic shift_clk,
  input  wire logic data_in,
  output logic      data_out,
  output logic      data_oe,
  // Oscillator
  input  wire logic crystal_in_pin,
  output logic      crystal_out_pin
);
  // ****************************************
  // Declarations
  // ****************************************
  srtc_cal_if  cal_bus ();

  logic        sel_m;
  logic        sel_q;
  logic        sck_m;
  logic        sck_q;
  logic        sck_d;
  logic        din_m;
  logic        din_q;
  logic        sck_rise;
  logic        sck_fall;
  logic [7:0]  shifted;

  srtc_state_t state_reg;
  srtc_state_t state_next;
  logic [2:0]  bit_reg;
  logic [2:0]  bit_next;
  logic [7:0]  sr_reg;
  logic [7:0]  sr_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_next;
  logic [4:0]  addr_reg;
  logic [4:0]  addr_next;
  logic [7:0]  rd_reg;
  logic [7:0]  rd_next;
  logic        dout_reg;
  logic        dout_next;
  logic        doe_reg;
  logic        doe_next;
  logic        wp_reg;
  logic        wp_next;
  logic        lock_reg;
  logic        lock_next;
  logic [7:0]  trk_reg;
  logic [7:0]  trk_next;

  srtc_byte_t  ram [`SRTC_RAM_DEPTH];
  srtc_regs_t  buf_reg;
  logic        ram_we;
  logic        buf_we;
  logic        cal_wr;
  logic        cal_ld;
  logic        snap;

  logic        burst;
  logic        cmd_ok;
  logic        ram_sp;
  logic        fetch_ram;
  logic        use_shadow;
  logic [4:0]  fetch_addr;
  logic [7:0]  rd_fetch;
  logic [4:0]  step_addr;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk) begin
    sel_m <= xfer_sel;
    sel_q <= sel_m;
    sck_m <= shift_clk;
    sck_q <= sck_m;
    sck_d <= sck_q;
    din_m <= data_in;
    din_q <= din_m;
  end

  assign sck_rise = sck_q & ~sck_d;
  assign sck_fall = ~sck_q & sck_d;
  assign shifted  = {din_q, sr_reg[7:1]};

  // ****************************************
  // Command decode
  // ****************************************
  assign cmd_ok = cmd_reg[`SRTC_CMD_EN_BIT];
  assign ram_sp = cmd_reg[`SRTC_CMD_RAM_BIT];
  assign burst  = (cmd_reg[`SRTC_CMD_ADDR_HI:`SRTC_CMD_ADDR_LO] == `SRTC_BURST_ADDR);

  // Burst address wraps inside the space so long reads keep cycling
  always_comb begin
    if (!burst) begin
      step_addr = addr_reg;
    end else if (ram_sp) begin
      step_addr = (addr_reg == `SRTC_RAM_LAST) ? 5'h00 : addr_reg + 5'h01;
    end else begin
      step_addr = (addr_reg == `SRTC_CLK_BURST_LAST) ? 5'h00 : addr_reg + 5'h01;
    end
  end

  // ****************************************
  // Read fetch
  // ****************************************
  always_comb begin
    if (state_reg == SRTC_CMD) begin
      fetch_ram  = shifted[`SRTC_CMD_RAM_BIT];
      fetch_addr = (shifted[`SRTC_CMD_ADDR_HI:`SRTC_CMD_ADDR_LO] == `SRTC_BURST_ADDR)
                   ? 5'h00 : shifted[`SRTC_CMD_ADDR_HI:`SRTC_CMD_ADDR_LO];
    end else begin
      fetch_ram  = ram_sp;
      fetch_addr = step_addr;
    end
    // First byte of a burst still comes from live regs: the copy is taken that same cycle
    use_shadow = (state_reg == SRTC_RD) && burst && !ram_sp;
    rd_fetch   = 8'h00;
    if (fetch_ram) begin
      if (fetch_addr < `SRTC_RAM_DEPTH) begin
        rd_fetch = ram[fetch_addr];
      end
    end else if (fetch_addr < `SRTC_CAL_REGS) begin
      rd_fetch = use_shadow ? cal_bus.shadow[fetch_addr[2:0]] : cal_bus.live[fetch_addr[2:0]];
    end else if (fetch_addr == `SRTC_CTRL_ADDR) begin
      rd_fetch = {wp_reg, 7'h00};
    end else if (fetch_addr == `SRTC_TRICKLE_ADDR) begin
      rd_fetch = trk_reg;
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    bit_next   = bit_reg;
    sr_next    = sr_reg;
    cmd_next   = cmd_reg;
    addr_next  = addr_reg;
    rd_next    = rd_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    wp_next    = wp_reg;
    lock_next  = lock_reg;
    trk_next   = trk_reg;
    ram_we     = 1'b0;
    buf_we     = 1'b0;
    cal_wr     = 1'b0;
    cal_ld     = 1'b0;
    snap       = 1'b0;
    if (!sel_q) begin
      state_next = SRTC_IDLE;
      doe_next   = 1'b0;
      bit_next   = 3'h0;
    end else begin
      case (state_reg)
        SRTC_IDLE: begin
          state_next = SRTC_CMD;
          bit_next   = 3'h0;
        end
        SRTC_CMD: begin
          if (sck_rise) begin
            sr_next  = shifted;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              cmd_next  = shifted;
              addr_next = fetch_addr;
              lock_next = wp_reg;
              if (shifted[`SRTC_CMD_RD_BIT]) begin
                state_next = SRTC_RD;
                rd_next    = rd_fetch;
                snap       = !shifted[`SRTC_CMD_RAM_BIT] &&
                             (shifted[`SRTC_CMD_ADDR_HI:`SRTC_CMD_ADDR_LO] == `SRTC_BURST_ADDR);
              end else begin
                state_next = SRTC_WR;
              end
            end
          end
        end
        SRTC_RD: begin
          if (sck_fall) begin
            doe_next  = 1'b1;
            dout_next = rd_reg[bit_reg];
          end
          if (sck_rise) begin
            doe_next = 1'b0;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              addr_next = step_addr;
              rd_next   = rd_fetch;
            end
          end
        end
        SRTC_WR: begin
          if (sck_rise) begin
            sr_next  = shifted;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              if (burst && ram_sp) begin
                ram_we    = cmd_ok && !wp_reg;
                addr_next = step_addr;
                if (addr_reg == `SRTC_RAM_LAST) begin
                  state_next = SRTC_DONE;
                end
              end else if (burst) begin
                buf_we    = 1'b1;
                addr_next = step_addr;
                if (addr_reg == `SRTC_CLK_BURST_LAST) begin
                  state_next = SRTC_DONE;
                  if (cmd_ok && !lock_reg) begin
                    cal_ld  = 1'b1;
                    wp_next = shifted[`SRTC_WP_BIT];
                  end
                end
              end else begin
                state_next = SRTC_DONE;
                if (cmd_ok && ram_sp) begin
                  ram_we = !wp_reg && (addr_reg < `SRTC_RAM_DEPTH);
                end else if (cmd_ok && addr_reg == `SRTC_CTRL_ADDR) begin
                  wp_next = shifted[`SRTC_WP_BIT];
                end else if (cmd_ok && !wp_reg) begin
                  cal_wr = (addr_reg < `SRTC_CAL_REGS);
                  if (addr_reg == `SRTC_TRICKLE_ADDR) begin
                    trk_next = shifted;
                  end
                end
              end
            end
          end
        end
        SRTC_DONE: begin
          // Extra clock cycles after a finished write are ignored
          state_next = SRTC_DONE;
        end
        default: begin
          state_next = SRTC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SRTC_IDLE;
      bit_reg   <= 3'h0;
      sr_reg    <= 8'h00;
      cmd_reg   <= 8'h00;
      addr_reg  <= 5'h00;
      rd_reg    <= 8'h00;
      dout_reg  <= 1'b0;
      doe_reg   <= 1'b0;
      wp_reg    <= `SRTC_RST_WP;
      lock_reg  <= 1'b0;
      trk_reg   <= `SRTC_RST_TRICKLE;
    end else begin
      state_reg <= state_next;
      bit_reg   <= bit_next;
      sr_reg    <= sr_next;
      cmd_reg   <= cmd_next;
      addr_reg  <= addr_next;
      rd_reg    <= rd_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      wp_reg    <= wp_next;
      lock_reg  <= lock_next;
      trk_reg   <= trk_next;
    end
  end

  // ****************************************
  // Scratchpad and burst staging
  // ****************************************
  // No reset on storage: contents are undefined at power-up
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[addr_reg] <= shifted;
    end
    if (buf_we && addr_reg < `SRTC_CAL_REGS) begin
      buf_reg[addr_reg[2:0]] <= shifted;
    end
  end

  // ****************************************
  // Calendar link
  // ****************************************
  assign cal_bus.wr_en    = cal_wr;
  assign cal_bus.wr_idx   = addr_reg[2:0];
  assign cal_bus.wr_byte  = shifted;
  assign cal_bus.ld_all   = cal_ld;
  assign cal_bus.ld_bytes = buf_reg;
  assign cal_bus.snap     = snap;

  srtc_calendar u_cal (
    .clk  (clk),
    .srst (srst),
    .bus  (cal_bus.cal)
  );

  srtc_tick #(
    .OSC_PER_SEC (OSC_PER_SEC)
  ) u_tick (
    .clk             (clk),
    .srst            (srst),
    .crystal_in_pin  (crystal_in_pin),
    .crystal_out_pin (crystal_out_pin),
    .bus             (cal_bus.tick)
  );

  assign data_out = dout_reg;
  assign data_oe  = doe_reg;
endmodule

// File: srtc_top_props.sv
// Port checker of the serial clock calendar
module srtc_top_props #(
  parameter int OSC_PER_SEC = 32768
) (
  // System
  input wire logic clk,
  input wire logic srst,
  // Serial port
  input wire logic xfer_sel,
  input wire logic shift_clk,
  input wire logic data_in,
  input wire logic data_out,
  input wire logic data_oe,
  // Oscillator
  input wire logic crystal_in_pin,
  input wire logic crystal_out_pin
);
  // **********
  // Shift clock rises seen in the current transfer
  // **********
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       rd_reg;
  logic       rd_next;
  logic       sclk_reg;
  always_comb begin
    cnt_next = cnt_reg;
    rd_next  = rd_reg;
    if (!xfer_sel) begin
      cnt_next = 4'h0;
    end else if (shift_clk && !sclk_reg && cnt_reg != 4'h8) begin
      cnt_next = cnt_reg + 4'h1;
      if (cnt_reg == 4'h0) begin
        rd_next = data_in;
      end
    end
  end
  always_ff @(posedge clk) begin
    cnt_reg  <= srst ? 4'h0 : cnt_next;
    rd_reg   <= srst ? 1'b0 : rd_next;
    sclk_reg <= shift_clk;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Device must answer within the sync delay, not at once
  sequence s_read_fall;
    xfer_sel && rd_reg && cnt_reg == 4'h8 ##0 $fell(shift_clk);
  endsequence
  sequence s_drive;
    ##[2:7] data_oe;
  endsequence
  AST_RESET_QUIET: assert property ($fell(srst) |-> !data_oe && !data_out && !crystal_out_pin)
    else $error("outputs active after reset");
  AST_SEL_LOW: assert property (!xfer_sel [*6] |-> !data_oe)
    else $error("data line driven while deselected");
  AST_RISE_RELEASE: assert property ($rose(shift_clk) && xfer_sel |-> ##[1:7] !data_oe)
    else $error("data line not released after shift rise");
  AST_DATA_HOLD: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("data changed while driven");
  AST_CMD_QUIET: assert property (xfer_sel && cnt_reg < 4'h8 |-> !data_oe)
    else $error("data driven during command byte");
  AST_WRITE_SILENT: assert property (xfer_sel && cnt_reg != 4'h0 && !rd_reg |-> !data_oe)
    else $error("data driven in a write");
  AST_READ_DRIVES: assert property (s_read_fall |-> s_drive)
    else $error("no read bit after shift fall");
  AST_XTAL_INV: assert property (crystal_out_pin |-> !$past(crystal_in_pin, 3))
    else $error("oscillator output not inverse of input");
endmodule

// File: srtc_host.sv
// Host model driving the three-wire serial port
module srtc_host (
  // System
  input  wire logic clk,
  // Serial port
  output logic      xfer_sel,
  output logic      shift_clk,
  output logic      data_in,
  input  wire logic data_out,
  input  wire logic data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  logic val;
  logic last = 1'b0;
  // A released line floats: show a changing level so no stale bit passes
  always_comb data_in = drv ? val : (data_oe === 1'b1 ? data_out : ~last);
  always @(posedge clk) last <= data_in;
  initial begin
    xfer_sel  = 1'b0;
    shift_clk = 1'b0;
    drv       = 1'b0;
    val       = 1'b0;
  end
  // **********
  // Half a link clock period, 200 ns period in all
  // **********
  task automatic half();
    repeat (4) @(posedge clk);
    #7;
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      shift_clk = 1'b0;
      drv       = 1'b1;
      val       = b[i];
      half();
      shift_clk = 1'b1;
      half();
    end
  endtask
  // Bit is taken just before the rise, while the device still drives it
  task automatic get(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      shift_clk = 1'b0;
      drv       = 1'b0;
      half();
      b[i]      = data_in;
      shift_clk = 1'b1;
      half();
    end
  endtask
  task automatic start(input logic [7:0] cmd);
    shift_clk = 1'b0;
    xfer_sel  = 1'b1;
    half();
    half();
    put(cmd);
  endtask
  task automatic stop();
    xfer_sel  = 1'b0;
    shift_clk = 1'b0;
    drv       = 1'b0;
    half();
    half();
  endtask
endmodule

// File: srtc_top_tb.sv
// Self-checking bench of the serial clock calendar
module srtc_top_tb;
  import srtc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC = 4;
  logic       clk;
  logic       srst;
  logic       xfer_sel;
  logic       shift_clk;
  logic       data_in;
  logic       data_out;
  logic       data_oe;
  logic       crystal_in_pin;
  logic       xo;
  int         bad_count = 0;
  int         n_tests = 0;
  int         seed = 25444;
  srtc_byte_t ram_m [31];
  srtc_byte_t tset [8] = '{8'h80, 8'h59, 8'h23, 8'h28, 8'h02, 8'h03, 8'h24, 8'h00};
  srtc_byte_t got;
  srtc_byte_t b;
  logic [4:0] a;
  srtc_top #(.OSC_PER_SEC(OSC)) i_srtc_top (.clk(clk), .srst(srst), .xfer_sel(xfer_sel),
    .shift_clk(shift_clk), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .crystal_in_pin(crystal_in_pin), .crystal_out_pin(xo));
  srtc_host i_srtc_host (.clk(clk), .xfer_sel(xfer_sel), .shift_clk(shift_clk),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input srtc_byte_t seen, input srtc_byte_t exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic srtc_byte_t cmd(input logic ram, input logic [4:0] ad, input logic r);
    return {1'b1, ram, ad, r};
  endfunction
  function automatic srtc_byte_t ctrl_exp(input srtc_byte_t v);
    return {v[7], 7'h00};
  endfunction
  task automatic wr(input srtc_byte_t c, input srtc_byte_t d);
    i_srtc_host.start(c);
    i_srtc_host.put(d);
    i_srtc_host.stop();
  endtask
  task automatic rchk(input logic ram, input logic [4:0] ad, input srtc_byte_t exp);
    i_srtc_host.start(cmd(ram, ad, 1'b1));
    i_srtc_host.get(got);
    i_srtc_host.stop();
    check(got, exp);
  endtask
  // Short crystal bursts keep tick moments predictable
  task automatic osc(input int n);
    repeat (2 * n) begin
      crystal_in_pin = ~crystal_in_pin;
      repeat (3) @(posedge clk);
      #7;
    end
    repeat (6) @(posedge clk);
    #7;
  endtask
  task automatic burst(input logic ram, input int n);
    i_srtc_host.start(cmd(ram, 5'h1F, 1'b0));
    for (int i = 0; i < n; i++) i_srtc_host.put(ram ? ram_m[i] : tset[i]);
    i_srtc_host.stop();
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    crystal_in_pin = 1'b0;
    repeat (4) @(posedge clk);
    #7;
    srst = 1'b0;
    repeat (4) @(posedge clk);
    #7;
    rchk(0, 5'h07, 8'h00);
    rchk(0, 5'h00, 8'h80);
    for (int i = 0; i < 3; i++) ram_m[i] = 8'($random(seed));
    burst(1, 3);
    rchk(1, 5'h01, ram_m[1]);
    i_srtc_host.start(cmd(1, 5'h1F, 1'b1));
    for (int i = 0; i < 3; i++) begin
      i_srtc_host.get(got);
      check(got, ram_m[i]);
    end
    i_srtc_host.stop();
    for (int i = 0; i < 6; i++) begin
      a = 5'(3 + {$random(seed)} % 28);
      ram_m[a] = 8'($random(seed));
      wr(cmd(1, a, 1'b0), ram_m[a]);
      rchk(1, a, ram_m[a]);
      a = 5'(9 + {$random(seed)} % 22);
      wr(cmd(0, a, 1'b0), 8'($random(seed)));
      rchk(0, a, 8'h00);
    end
    wr(cmd(1, 5'h00, 1'b0) & 8'h7F, ~ram_m[0]);
    rchk(1, 5'h00, ram_m[0]);
    wr(cmd(0, 5'h07, 1'b0), 8'hFF);
    rchk(0, 5'h07, ctrl_exp(8'hFF));
    wr(cmd(1, 5'h01, 1'b0), ~ram_m[1]);
    rchk(1, 5'h01, ram_m[1]);
    burst(0, 8);
    rchk(0, 5'h01, 8'h00);
    wr(cmd(0, 5'h07, 1'b0), 8'h00);
    wr(cmd(0, 5'h08, 1'b0), 8'h5A);
    rchk(0, 5'h08, 8'h5A);
    wr(cmd(1, 5'h05, 1'b0), 8'h3C);
    i_srtc_host.start(cmd(1, 5'h05, 1'b0));
    i_srtc_host.stop();
    i_srtc_host.start(cmd(1, 5'h05, 1'b0));
    i_srtc_host.put(8'hA5);
    i_srtc_host.put(8'hC3);
    i_srtc_host.stop();
    i_srtc_host.start(cmd(1, 5'h05, 1'b1));
    for (int i = 0; i < 2; i++) begin
      i_srtc_host.get(got);
      check(got, 8'hA5);
    end
    i_srtc_host.stop();
    burst(0, 7);
    rchk(0, 5'h01, 8'h00);
    burst(0, 8);
    i_srtc_host.start(cmd(0, 5'h1F, 1'b1));
    for (int i = 0; i < 8; i++) begin
      i_srtc_host.get(got);
      check(got, tset[i]);
    end
    i_srtc_host.stop();
    wr(cmd(0, 5'h00, 1'b0), 8'h59);
    osc(OSC);
    check({7'h00, xo}, 8'h01);
    rchk(0, 5'h03, 8'h29);
    rchk(0, 5'h02, 8'h00);
    rchk(0, 5'h00, 8'h00);
    wr(cmd(0, 5'h02, 1'b0), 8'h91);
    wr(cmd(0, 5'h01, 1'b0), 8'h59);
    wr(cmd(0, 5'h00, 1'b0), 8'h59);
    osc(OSC);
    rchk(0, 5'h02, 8'hB2);
    wr(cmd(0, 5'h00, 1'b0), 8'hA5);
    osc(2 * OSC);
    check({7'h00, xo}, 8'h00);
    rchk(0, 5'h00, 8'hA5);
    wrap_up();
  end
endmodule
bind srtc_top srtc_top_props #(.OSC_PER_SEC(OSC_PER_SEC)) i_srtc_top_props (.clk(clk),
  .srst(srst), .xfer_sel(xfer_sel), .shift_clk(shift_clk), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .crystal_in_pin(crystal_in_pin),
  .crystal_out_pin(crystal_out_pin));
